// ===== rtl/flash_cmd_defines.vh
/*
  command codes, read-source codes and timing for the flash command state machine.
  assumes inclusion by bare name from rtl files; definitions only.
*/
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH

// command bytes
`define CMD_READ_ARRAY 8'hFF
`define CMD_PGM_SETUP_A 8'h40
`define CMD_PGM_SETUP_B 8'h10
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hD0
`define CMD_SUSPEND 8'hB0
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_ID 8'h90

// status bit positions
`define SR_READY_BIT 7
`define SR_ERASE_ERR_BIT 5
`define SR_ERASE_SUSP_BIT 6
`define SR_PGM_SUSP_BIT 2

// read source selection
`define SRC_ARRAY 2'h0
`define SRC_STATUS 2'h1
`define SRC_ID 2'h2

// reset value of status
`define SR_RESET 8'h80

// default busy times and clock period in ns
`define PGM_TIME_NS 1000
`define ERASE_TIME_NS 5000
`define CLK_PERIOD_NS 10

`endif

// ===== rtl/flash_command_state_machine.v
/*
  command state machine of a byte-wide flash: decodes host command writes,
  selects what a read returns, and runs busy timers standing in for the
  internal program and erase algorithms.
  assumes writes arrive as one-cycle strobes synchronous to REF_CLK and that
  the array storage itself sits outside, driven by the start pulses here.
*/
`timescale 1ns/100ps
`include "flash_cmd_defines.vh"

// Operation
// - decode FF 40 10 20 D0 B0 70 50 90
// - idle states follow common command transitions
// - reads select array, identifier or status
// - program busy: ready low, only suspend, none when nested in erase suspend
// - erase busy: ready low, only suspend
// - program setup takes next write as data
// - program suspend: D0 resumes, 70 status
// - erase suspend allows program, resume, reads
// - FF data runs program, array unchanged
// - after program settle in status, error only on OP_FAIL with data not FF
// - FF in read status returns read array
module flash_command_state_machine #(
  parameter PGM_CYCLES = `PGM_TIME_NS / `CLK_PERIOD_NS,
  parameter ERASE_CYCLES = `ERASE_TIME_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // host write strobe
  input wire WR_STB,
  input wire [19:0] WR_ADDR,
  input wire [7:0] WR_DATA,
  // status of the internal algorithm error, sampled at completion
  input wire OP_FAIL,
  // array start pulses
  output reg PGM_START,
  output reg [19:0] PGM_ADDR,
  output reg [7:0] PGM_DATA,
  output reg PGM_WRITE_EN,
  output reg ERASE_START,
  output reg [19:0] ERASE_ADDR,
  // read selection and status
  output reg [1:0] READ_SRC,
  output reg [7:0] STATUS
);

  // state codes
  localparam S_RD_ARRAY = 4'h0;
  localparam S_RD_STATUS = 4'h1;
  localparam S_RD_ID = 4'h2;
  localparam S_PGM_SETUP = 4'h3;
  localparam S_PGM_BUSY = 4'h4;
  localparam S_PGM_DONE = 4'h5;
  localparam S_PSUSP_STAT = 4'h6;
  localparam S_PSUSP_ARR = 4'h7;
  localparam S_ERS_SETUP = 4'h8;
  localparam S_ERS_ERR = 4'h9;
  localparam S_ERS_BUSY = 4'hA;
  localparam S_ERS_DONE = 4'hB;
  localparam S_ESUSP_STAT = 4'hC;
  localparam S_ESUSP_ARR = 4'hD;

  reg [3:0] state_r; // current state
  reg [3:0] state_nxt; // next state
  reg [31:0] pgm_cnt_r; // program cycles left
  reg [31:0] ers_cnt_r; // erase cycles left
  reg pgm_in_esusp_r; // program nested in erase suspend
  reg err_r; // sticky erase command or op error
  reg ready_r; // ready bit
  reg err_nxt; // next error bit, also feeds status so both move together
  reg ers_susp_r; // erase suspended flag

  // decoded command bytes
  wire c_ff = WR_DATA == `CMD_READ_ARRAY;
  wire c_pgm = (WR_DATA == `CMD_PGM_SETUP_A) || (WR_DATA == `CMD_PGM_SETUP_B);
  wire c_ers = WR_DATA == `CMD_ERASE_SETUP;
  wire c_d0 = WR_DATA == `CMD_CONFIRM;
  wire c_sus = WR_DATA == `CMD_SUSPEND;
  wire c_rs = WR_DATA == `CMD_READ_STATUS;
  wire c_clr = WR_DATA == `CMD_CLEAR_STATUS;
  wire c_id = WR_DATA == `CMD_READ_ID;
  wire pgm_end = (state_r == S_PGM_BUSY) && (pgm_cnt_r == 32'h0000_0001);
  wire ers_end = (state_r == S_ERS_BUSY) && (ers_cnt_r == 32'h0000_0001);

  // next-state decode
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_RD_ARRAY, S_RD_STATUS, S_RD_ID, S_PGM_DONE, S_ERS_ERR, S_ERS_DONE: begin
        if (WR_STB) begin
          if (c_ff || c_sus || c_clr)
            state_nxt = S_RD_ARRAY;
          else if (c_rs)
            state_nxt = S_RD_STATUS;
          else if (c_id)
            state_nxt = S_RD_ID;
          else if (c_pgm)
            state_nxt = S_PGM_SETUP;
          else if (c_ers)
            state_nxt = S_ERS_SETUP;
        end
      end
      S_PGM_SETUP: begin
        if (WR_STB)
          state_nxt = S_PGM_BUSY;
      end
      S_PGM_BUSY: begin
        if (pgm_end)
          state_nxt = pgm_in_esusp_r ? S_ESUSP_STAT : S_PGM_DONE;
        else if (WR_STB && c_sus && !pgm_in_esusp_r)
          state_nxt = S_PSUSP_STAT;
      end
      S_PSUSP_STAT, S_PSUSP_ARR: begin
        if (WR_STB) begin
          if (c_d0)
            state_nxt = S_PGM_BUSY;
          else if (c_rs)
            state_nxt = S_PSUSP_STAT;
          else
            state_nxt = S_PSUSP_ARR;
        end
      end
      S_ERS_SETUP: begin
        if (WR_STB)
          state_nxt = c_d0 ? S_ERS_BUSY : S_ERS_ERR;
      end
      S_ERS_BUSY: begin
        if (ers_end)
          state_nxt = S_ERS_DONE;
        else if (WR_STB && c_sus)
          state_nxt = S_ESUSP_STAT;
      end
      S_ESUSP_STAT, S_ESUSP_ARR: begin
        if (WR_STB) begin
          if (c_d0)
            state_nxt = S_ERS_BUSY;
          else if (c_rs)
            state_nxt = S_ESUSP_STAT;
          else if (c_pgm)
            state_nxt = S_PGM_SETUP;
          else
            state_nxt = S_ESUSP_ARR;
        end
      end
      default: state_nxt = S_RD_ARRAY;
    endcase
  end

  // error bit next value; a set wins over a clear in the same cycle
  always @* begin
    err_nxt = err_r;
    if (state_r == S_ERS_SETUP && WR_STB && !c_d0)
      err_nxt = 1'b1;
    else if ((pgm_end && PGM_WRITE_EN && OP_FAIL) || (ers_end && OP_FAIL))
      err_nxt = 1'b1;
    else if (WR_STB && c_clr && ready_r && state_r != S_PGM_SETUP &&
             state_r != S_ERS_SETUP)
      err_nxt = 1'b0;
  end

  // state, counters, status and array strobes
  always @(posedge REF_CLK) begin
    if (RST) begin
      state_r <= S_RD_ARRAY;
      pgm_cnt_r <= 32'h0;
      ers_cnt_r <= 32'h0;
      pgm_in_esusp_r <= 1'b0;
      err_r <= 1'b0;
      ready_r <= 1'b1;
      ers_susp_r <= 1'b0;
      PGM_START <= 1'b0;
      PGM_ADDR <= 20'h0;
      PGM_DATA <= 8'hFF;
      PGM_WRITE_EN <= 1'b0;
      ERASE_START <= 1'b0;
      ERASE_ADDR <= 20'h0;
    end else begin
      state_r <= state_nxt;
      PGM_START <= 1'b0;
      ERASE_START <= 1'b0;
      // program data write starts the algorithm
      if (state_r == S_PGM_SETUP && WR_STB) begin
        PGM_START <= 1'b1;
        PGM_ADDR <= WR_ADDR;
        PGM_DATA <= WR_DATA;
        PGM_WRITE_EN <= ~c_ff;
        pgm_cnt_r <= PGM_CYCLES;
        pgm_in_esusp_r <= ers_susp_r;
      end else if (state_r == S_PGM_BUSY && pgm_cnt_r != 32'h0) begin
        pgm_cnt_r <= pgm_cnt_r - 32'h0000_0001; // counter holds over suspend
      end
      // erase confirm starts the algorithm
      if (state_r == S_ERS_SETUP && WR_STB && c_d0) begin
        ERASE_START <= 1'b1;
        ERASE_ADDR <= WR_ADDR;
        ers_cnt_r <= ERASE_CYCLES;
      end else if (state_r == S_ERS_BUSY && ers_cnt_r != 32'h0) begin
        ers_cnt_r <= ers_cnt_r - 32'h0000_0001;
      end
      // ready bit low only while busy
      ready_r <= (state_nxt != S_PGM_BUSY) && (state_nxt != S_ERS_BUSY);
      ers_susp_r <= (state_nxt == S_ESUSP_STAT) || (state_nxt == S_ESUSP_ARR) ||
        ((state_nxt == S_PGM_SETUP || state_nxt == S_PGM_BUSY) && ers_susp_r);
      // sticky error; FF program data never flags
      err_r <= err_nxt;
    end
  end

  // read source and status byte
  always @(posedge REF_CLK) begin
    if (RST) begin
      READ_SRC <= `SRC_ARRAY;
      STATUS <= `SR_RESET;
    end else begin
      if (state_nxt == S_RD_ARRAY || state_nxt == S_PSUSP_ARR || state_nxt == S_ESUSP_ARR)
        READ_SRC <= `SRC_ARRAY;
      else if (state_nxt == S_RD_ID)
        READ_SRC <= `SRC_ID;
      else
        READ_SRC <= `SRC_STATUS;
      STATUS <= 8'h00;
      STATUS[`SR_READY_BIT] <= (state_nxt != S_PGM_BUSY) && (state_nxt != S_ERS_BUSY);
      STATUS[`SR_ERASE_SUSP_BIT] <= (state_nxt == S_ESUSP_STAT) || (state_nxt == S_ESUSP_ARR);
      STATUS[`SR_PGM_SUSP_BIT] <= (state_nxt == S_PSUSP_STAT) || (state_nxt == S_PSUSP_ARR);
      STATUS[`SR_ERASE_ERR_BIT] <= err_nxt;
    end
  end

endmodule

// ===== verification/flash_cmd_sva.sv
/*
  port assertions for the flash command state machine.
  assumes a bind onto the design top module.
*/
`timescale 1ns/100ps
module flash_cmd_sva (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // host writes
  input wire WR_STB,
  input wire [19:0] WR_ADDR,
  input wire [7:0] WR_DATA,
  // design outputs
  input wire PGM_START,
  input wire [19:0] PGM_ADDR,
  input wire [7:0] PGM_DATA,
  input wire PGM_WRITE_EN,
  input wire ERASE_START,
  input wire [1:0] READ_SRC,
  input wire [7:0] STATUS
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // source expected after a command taken in plain read array
  wire [1:0] src_exp = (WR_DATA == 8'h90) ? 2'h2 :
    (WR_DATA == 8'h70 || WR_DATA == 8'h40 || WR_DATA == 8'h10 || WR_DATA == 8'h20) ? 2'h1 : 2'h0;
  // read array with no suspension pending
  wire idle = READ_SRC == 2'h0 && !STATUS[6] && !STATUS[2];
  property p_idle; WR_STB && idle && WR_DATA != 8'hD0 |=> READ_SRC == $past(src_exp); endproperty
  property p_busy; WR_STB && !STATUS[7] |=> READ_SRC == 2'h1; endproperty
  property p_pbusy; $rose(PGM_START) |-> !STATUS[7]; endproperty
  property p_erase; ERASE_START |-> !STATUS[7] && $past(WR_STB) && $past(WR_DATA) == 8'hD0; endproperty
  property p_pulse; PGM_START |=> !PGM_START; endproperty
  property p_pdata; PGM_START |-> $past(WR_STB) && PGM_DATA == $past(WR_DATA) &&
    PGM_ADDR == $past(WR_ADDR); endproperty
  property p_wen; PGM_START |-> PGM_WRITE_EN == (PGM_DATA != 8'hFF); endproperty
  property p_done; $rose(STATUS[7]) |-> READ_SRC == 2'h1; endproperty
  a_idle: assert property (p_idle) else $error("idle command");
  a_busy: assert property (p_busy) else $error("busy write");
  a_pbusy: assert property (p_pbusy) else $error("program ready");
  a_erase: assert property (p_erase) else $error("erase start");
  a_pulse: assert property (p_pulse) else $error("start pulse");
  a_pdata: assert property (p_pdata) else $error("program byte");
  a_wen: assert property (p_wen) else $error("write enable");
  a_done: assert property (p_done) else $error("done source");
  // main scenarios
  c_erase: cover property (ERASE_START);
  c_esusp: cover property (STATUS[6]);
  c_ffpgm: cover property (PGM_START && !PGM_WRITE_EN);
endmodule
bind flash_command_state_machine flash_cmd_sva chk_i (.REF_CLK(REF_CLK), .RST(RST),
  .WR_STB(WR_STB), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .PGM_START(PGM_START),
  .PGM_ADDR(PGM_ADDR), .PGM_DATA(PGM_DATA), .PGM_WRITE_EN(PGM_WRITE_EN),
  .ERASE_START(ERASE_START), .READ_SRC(READ_SRC), .STATUS(STATUS));

// ===== verification/host_model.sv
/*
  host model: issues command and data writes as one-cycle strobes.
  assumes the device takes a write on the rising clock edge.
*/
`timescale 1ns/100ps
module host_model (
  // clock
  input wire clk,
  // write bus toward the device
  output logic stb = 1'b0,
  output logic [19:0] addr = 20'h00000,
  output logic [7:0] data = 8'h00
);
  // one write, then the released bus shows inverted values
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    stb <= 1'b1;
    addr <= a;
    data <= d;
    @(posedge clk);
    stb <= 1'b0;
    addr <= ~a;
    data <= ~d;
    #1;
  endtask
endmodule

// ===== verification/tb.sv
/*
  self-checking bench for the flash command state machine.
  assumes host_model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
module tb;
  logic REF_CLK = 1'b0; // 100 MHz
  logic RST = 1'b1; // synchronous reset
  logic OP_FAIL = 1'b0; // algorithm failure
  wire WR_STB, PGM_START, PGM_WRITE_EN, ERASE_START;
  wire [19:0] WR_ADDR, PGM_ADDR, ERASE_ADDR;
  wire [7:0] WR_DATA, PGM_DATA, STATUS;
  wire [1:0] READ_SRC;
  int failures = 0;
  int n_tests = 0;
  initial forever #5 REF_CLK = ~REF_CLK;
  host_model host (.clk(REF_CLK), .stb(WR_STB), .addr(WR_ADDR), .data(WR_DATA));
  flash_command_state_machine #(.PGM_CYCLES(4), .ERASE_CYCLES(4)) dut (.REF_CLK(REF_CLK),
    .RST(RST), .WR_STB(WR_STB), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .OP_FAIL(OP_FAIL),
    .PGM_START(PGM_START), .PGM_ADDR(PGM_ADDR), .PGM_DATA(PGM_DATA),
    .PGM_WRITE_EN(PGM_WRITE_EN), .ERASE_START(ERASE_START), .ERASE_ADDR(ERASE_ADDR),
    .READ_SRC(READ_SRC), .STATUS(STATUS));
  // compare and count
  task automatic chk(string nm, logic [19:0] seen, logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // wait for ready under a bound
  task automatic wait_ready();
    for (int i = 0; i < 50 && STATUS[7] !== 1'b1; i++) @(posedge REF_CLK);
    #1;
    chk("ready", STATUS[7], 1'b1);
  endtask
  // each idle command except program and erase setup, then back to array
  task automatic t_idle();
    logic [7:0] c [5] = '{8'hFF, 8'hB0, 8'h50, 8'h70, 8'h90};
    logic [1:0] s [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
    for (int i = 0; i < 5; i++) begin
      host.wr(20'h0, c[i]);
      chk("src", READ_SRC, s[i]);
      host.wr(20'h0, 8'hFF);
      chk("src_ff", READ_SRC, 2'h0);
    end
  endtask
  // program one byte, a command ignored while busy
  task automatic t_pgm(logic [7:0] cmd, logic [7:0] d);
    host.wr(20'h0, cmd);
    chk("setup_src", READ_SRC, 2'h1);
    host.wr(20'h12345, d);
    chk("start", PGM_START, 1'b1);
    chk("pdata", PGM_DATA, d);
    chk("paddr", PGM_ADDR, 20'h12345);
    chk("wen", PGM_WRITE_EN, d != 8'hFF);
    host.wr(20'h0, 8'h90);
    chk("ignored", {STATUS[7], READ_SRC}, 3'h1);
    wait_ready();
    chk("done", {STATUS[5], READ_SRC}, 3'h1);
  endtask
  // program suspend, reads and resume
  task automatic t_psusp();
    host.wr(20'h0, 8'h10);
    host.wr(20'h00042, 8'h33);
    host.wr(20'h0, 8'hB0);
    chk("psusp", {STATUS[2], READ_SRC}, 3'h5);
    host.wr(20'h0, 8'hFF);
    chk("psusp_arr", READ_SRC, 2'h0);
    host.wr(20'h0, 8'h70);
    chk("psusp_st", READ_SRC, 2'h1);
    host.wr(20'h0, 8'hD0);
    chk("resume", {STATUS[7], STATUS[2]}, 2'h0);
    wait_ready();
  endtask
  // command error, clear, erase with suspend and nested program
  task automatic t_erase();
    host.wr(20'h0, 8'h20);
    host.wr(20'h0, 8'h50);
    chk("cmd_err", {STATUS[5], READ_SRC}, 3'h5);
    host.wr(20'h0, 8'h50);
    chk("clear", {STATUS[7], STATUS[5], READ_SRC}, 4'h8);
    host.wr(20'h30000, 8'h20);
    host.wr(20'h30000, 8'hD0);
    chk("estart", {ERASE_START, STATUS[7]}, 2'h2);
    chk("eaddr", ERASE_ADDR, 20'h30000);
    host.wr(20'h0, 8'hB0);
    chk("esusp", STATUS[6], 1'b1);
    host.wr(20'h0, 8'hFF);
    chk("esusp_arr", READ_SRC, 2'h0);
    host.wr(20'h0, 8'h40);
    host.wr(20'h00005, 8'h0F);
    chk("nested", PGM_START, 1'b1);
    wait_ready();
    host.wr(20'h0, 8'hD0);
    chk("eresume", {STATUS[7], STATUS[6]}, 2'h0);
    wait_ready();
  endtask
  // verdict
  task automatic final_report();
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    #1;
    chk("rst", {READ_SRC, STATUS}, 10'h080);
    t_idle();
    t_pgm(8'h40, 8'hA5);
    @(posedge REF_CLK) OP_FAIL <= 1'b1;
    t_pgm(8'h10, 8'hFF);
    @(posedge REF_CLK) OP_FAIL <= 1'b0;
    host.wr(20'h0, 8'hFF);
    chk("ff_arr", READ_SRC, 2'h0);
    t_psusp();
    t_erase();
    final_report();
  end
  // watchdog
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule
